// ==== rtl/ccu_consts.vh ====
`ifndef CCU_CONSTS_VH
`define CCU_CONSTS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCU_A_T3LO 4'h0
`define CCU_A_T3HI 4'h1
`define CCU_A_T3CTL 4'h2
`define CCU_A_FLAGS2 4'h3
`define CCU_A_EN2 4'h4
`define CCU_A_PRIO2 4'h5
`define CCU_A_C1CTL 4'h6
`define CCU_A_C1LO 4'h7
`define CCU_A_C1HI 4'h8
`define CCU_A_C2CTL 4'h9
`define CCU_A_C2LO 4'hA
`define CCU_A_C2HI 4'hB
`define CCU_A_T1LO 4'hC
`define CCU_A_T1HI 4'hD
`define CCU_A_FLAGS1 4'hE
// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define CCU_PRIO2_RST 8'h1F
`define CCU_T3_ON 0
`define CCU_T3_SEL_LO 3
`define CCU_T3_SEL_HI 6
`define CCU_FLAGS2_T3OV 1
`define CCU_FLAGS2_C2 0
`define CCU_FLAGS1_C1 2
`define CCU_FLAGS1_T1OV 0
`define CCU_CTL_MASK 8'h3F
// ----------------------------------------
// mode codes
// ----------------------------------------
`define CCU_M_OFF 4'h0
`define CCU_M_TOGGLE 4'h2
`define CCU_M_CAP_FALL 4'h4
`define CCU_M_CAP_RISE 4'h5
`define CCU_M_CAP_4 4'h6
`define CCU_M_CAP_16 4'h7
`define CCU_M_SET_HI 4'h8
`define CCU_M_SET_LO 4'h9
`define CCU_M_SWINT 4'hA
`define CCU_M_TRIG 4'hB
`define CCU_PS_4 4'h3
`define CCU_PS_16 4'hF
`endif

// ==== rtl/ccu_top.v ====
// The plain strobed port and the register offsets were chosen for this implementation.
`include "ccu_consts.vh"
`default_nettype none
// Operation
// - third timer counts up, wraps, sets flag
// - overflow request only when enable set
// - code 1011 match sets flag, clears timer
// - trigger clear never sets overflow flag
// - software timer write beats trigger clear
// - channel control bits 7:6 read zero
// - bits 5:4 hold duty low bits
// - code 0000 disables and resets channel
// - capture codes choose edge and prescale
// - code 0010 toggles output on match
// - codes 1000/1001 preset output, force on match
// - code 1010 flags match, output unchanged
// - value bytes and control software accessible
// - channels differ in trigger behaviour, timebase select and interrupt enable (channel 0 request ungated)
// - timebase select picks first or third timer
// - capture copies timer, sets sticky flag
// - new capture overwrites unread value
// - output-mode port write can trigger capture
// - prescale counter cleared outside capture modes
// - prescale change keeps counter, may flag
// - compare runs every cycle
// - zero control forces output latch low
module ccu_top #(
  parameter W = 16
) (
  input wire mclk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire [1:0] chan_pin_in,
  input wire [1:0] port_c_direction,
  input wire [1:0] port_latch,
  output reg [1:0] chan_pin_out,
  output reg [1:0] chan_pin_oe_n,
  input wire [W-1:0] first_timer,
  output reg first_timer_clear,
  output reg adc_start,
  output reg t3_overflow_irq,
  output reg [1:0] chan_irq
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function is_cap;
    input [3:0] m;
    is_cap = (m[3:2] == 2'b01);
  endfunction
  function is_cmp;
    input [3:0] m;
    is_cmp = (m == `CCU_M_TOGGLE) || (m[3:2] == 2'b10);
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [W-1:0] t3_reg;
  reg [7:0] third_timer_ctrl;
  reg [7:0] en2_reg;
  reg [7:0] prio2_reg;
  reg t3_overflow_flag;
  reg [5:0] ctl_reg [0:1];
  reg [W-1:0] val_reg [0:1];
  reg [1:0] flag_reg;
  reg [3:0] ps_reg [0:1];
  reg [1:0] cout_reg;
  reg [1:0] s1_reg, s2_reg, s3_reg;
  reg [1:0] pin_prev_reg;
  reg [1:0] lat_prev_reg;

  wire [1:0] tb_sel = {third_timer_ctrl[`CCU_T3_SEL_HI], third_timer_ctrl[`CCU_T3_SEL_LO]};
  // channel 0 uses third timer when select is 1x; channel 1 when nonzero
  wire [1:0] use_t3 = {(tb_sel != 2'b00), tb_sel[1]};
  wire [W-1:0] tb0 = use_t3[0] ? t3_reg : first_timer;
  wire [W-1:0] tb1 = use_t3[1] ? t3_reg : first_timer;

  // ----------------------------------------
  // pin path: synchronised input, or latch when output
  // ----------------------------------------
  wire [1:0] pin_view_prev;
  assign pin_view_prev[0] = port_c_direction[0] ? pin_prev_reg[0] : lat_prev_reg[0];
  assign pin_view_prev[1] = port_c_direction[1] ? pin_prev_reg[1] : lat_prev_reg[1];
  // agreement of second and third stages filters a metastable first stage
  wire [1:0] pin_now;
  assign pin_now[0] = port_c_direction[0] ? ((s2_reg[0] == s3_reg[0]) ? s3_reg[0]
                      : pin_prev_reg[0]) : port_latch[0];
  assign pin_now[1] = port_c_direction[1] ? ((s2_reg[1] == s3_reg[1]) ? s3_reg[1]
                      : pin_prev_reg[1]) : port_latch[1];
  wire [1:0] rise = pin_now & ~pin_view_prev;
  wire [1:0] fall = ~pin_now & pin_view_prev;

  // ----------------------------------------
  // per-channel events
  // ----------------------------------------
  wire [3:0] m0 = ctl_reg[0][3:0];
  wire [3:0] m1 = ctl_reg[1][3:0];
  wire [1:0] match;
  assign match[0] = is_cmp(m0) && (val_reg[0] == tb0);
  assign match[1] = is_cmp(m1) && (val_reg[1] == tb1);

  reg [1:0] cap_ev;
  reg [3:0] ps_next [0:1];
  integer i;
  integer k;
  reg [3:0] mm;
  reg rr;
  always @* begin
    mm = 4'h0;
    rr = 1'b0;
    for (k = 0; k < 2; k = k + 1) begin
      mm = ctl_reg[k][3:0];
      rr = rise[k];
      ps_next[k] = ps_reg[k];
      cap_ev[k] = 1'b0;
      if (!is_cap(mm)) begin
        ps_next[k] = 4'h0;
      end else if (mm == `CCU_M_CAP_FALL) begin
        cap_ev[k] = fall[k];
      end else if (mm == `CCU_M_CAP_RISE) begin
        cap_ev[k] = rr;
      end else if (rr) begin
        // counter kept across prescale switches, so first capture may be early
        if ((mm == `CCU_M_CAP_4 && ps_reg[k][1:0] == `CCU_PS_4 - 4'h0) ||
            (mm == `CCU_M_CAP_16 && ps_reg[k] == `CCU_PS_16)) begin
          cap_ev[k] = 1'b1;
          ps_next[k] = 4'h0;
        end else begin
          ps_next[k] = ps_reg[k] + 4'h1;
        end
      end
    end
  end

  // special event trigger clears whichever timer is the channel's base
  wire [1:0] trig = {match[1] && m1 == `CCU_M_TRIG, match[0] && m0 == `CCU_M_TRIG};
  wire t3_clr = (trig[0] && use_t3[0]) || (trig[1] && use_t3[1]);
  wire t1_clr = (trig[0] && !use_t3[0]) || (trig[1] && !use_t3[1]);

  // ----------------------------------------
  // register writes and timer
  // ----------------------------------------
  wire wr_t3lo = wr && addr == `CCU_A_T3LO;
  wire wr_t3hi = wr && addr == `CCU_A_T3HI;
  wire wr_f2 = wr && addr == `CCU_A_FLAGS2;
  wire wr_f1 = wr && addr == `CCU_A_FLAGS1;
  wire [1:0] wr_ctl = {wr && addr == `CCU_A_C2CTL, wr && addr == `CCU_A_C1CTL};
  wire [1:0] wr_lo = {wr && addr == `CCU_A_C2LO, wr && addr == `CCU_A_C1LO};
  wire [1:0] wr_hi = {wr && addr == `CCU_A_C2HI, wr && addr == `CCU_A_C1HI};
  wire t3_wrap = third_timer_ctrl[`CCU_T3_ON] && (&t3_reg);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t3_reg <= {W{1'b0}};
      third_timer_ctrl <= 8'h00;
      en2_reg <= 8'h00;
      prio2_reg <= `CCU_PRIO2_RST;
      t3_overflow_flag <= 1'b0;
      flag_reg <= 2'b00;
      cout_reg <= 2'b00;
      s1_reg <= 2'b00;
      s2_reg <= 2'b00;
      s3_reg <= 2'b00;
      pin_prev_reg <= 2'b00;
      lat_prev_reg <= 2'b00;
      ctl_reg[0] <= 6'h00;
      ctl_reg[1] <= 6'h00;
      val_reg[0] <= {W{1'b0}};
      val_reg[1] <= {W{1'b0}};
      ps_reg[0] <= 4'h0;
      ps_reg[1] <= 4'h0;
    end else begin
      s1_reg <= chan_pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_prev_reg <= pin_now;
      lat_prev_reg <= port_latch;
      if (wr_t3lo) begin
        t3_reg[7:0] <= wdata;
      end else if (wr_t3hi) begin
        t3_reg[W-1:8] <= wdata[W-9:0];
      end else if (t3_clr) begin
        t3_reg <= {W{1'b0}};
      end else if (third_timer_ctrl[`CCU_T3_ON]) begin
        t3_reg <= t3_reg + {{(W-1){1'b0}}, 1'b1};
      end
      if (wr && addr == `CCU_A_T3CTL) third_timer_ctrl <= wdata;
      if (wr && addr == `CCU_A_EN2) en2_reg <= wdata;
      if (wr && addr == `CCU_A_PRIO2) prio2_reg <= wdata;
      // a wrap only via counting, never via trigger clear; set beats clear
      if (t3_wrap && !t3_clr && !wr_t3lo && !wr_t3hi) begin
        t3_overflow_flag <= 1'b1;
      end else if (wr_f2) begin
        t3_overflow_flag <= wdata[`CCU_FLAGS2_T3OV];
      end
      for (i = 0; i < 2; i = i + 1) begin
        ps_reg[i] <= ps_next[i];
        if (wr_ctl[i]) begin
          ctl_reg[i] <= wdata[5:0];
          if (wdata[3:0] == `CCU_M_OFF) begin
            ps_reg[i] <= 4'h0;
            cout_reg[i] <= 1'b0;
          end else if (wdata[3:0] == `CCU_M_SET_HI) begin
            cout_reg[i] <= 1'b0;
          end else if (wdata[3:0] == `CCU_M_SET_LO) begin
            cout_reg[i] <= 1'b1;
          end
        end else if (match[i]) begin
          case (ctl_reg[i][3:0])
            `CCU_M_TOGGLE: cout_reg[i] <= ~cout_reg[i];
            `CCU_M_SET_HI: cout_reg[i] <= 1'b1;
            `CCU_M_SET_LO: cout_reg[i] <= 1'b0;
            default: cout_reg[i] <= cout_reg[i];
          endcase
        end
        if (cap_ev[i]) begin
          val_reg[i] <= (i == 0) ? tb0 : tb1;
        end else if (wr_lo[i]) begin
          val_reg[i][7:0] <= wdata;
        end else if (wr_hi[i]) begin
          val_reg[i][W-1:8] <= wdata[W-9:0];
        end
      end
      // hardware set wins over software clear
      if (cap_ev[0] || match[0]) begin
        flag_reg[0] <= 1'b1;
      end else if (wr_f1) begin
        flag_reg[0] <= wdata[`CCU_FLAGS1_C1];
      end
      if (cap_ev[1] || match[1]) begin
        flag_reg[1] <= 1'b1;
      end else if (wr_f2) begin
        flag_reg[1] <= wdata[`CCU_FLAGS2_C2];
      end
    end
  end

  // ----------------------------------------
  // outputs and read port
  // ----------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      chan_pin_out <= 2'b00;
      chan_pin_oe_n <= 2'b11;
      first_timer_clear <= 1'b0;
      adc_start <= 1'b0;
      t3_overflow_irq <= 1'b0;
      chan_irq <= 2'b00;
    end else begin
      chan_pin_out <= cout_reg;
      chan_pin_oe_n <= port_c_direction;
      first_timer_clear <= t1_clr;
      adc_start <= trig[1];
      t3_overflow_irq <= t3_overflow_flag && en2_reg[`CCU_FLAGS2_T3OV];
      chan_irq <= {flag_reg[1] && en2_reg[`CCU_FLAGS2_C2], flag_reg[0]};
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          `CCU_A_T3LO: rdata <= t3_reg[7:0];
          `CCU_A_T3HI: rdata <= t3_reg[W-1:8];
          `CCU_A_T3CTL: rdata <= third_timer_ctrl;
          `CCU_A_FLAGS2: rdata <= {6'h00, t3_overflow_flag, flag_reg[1]};
          `CCU_A_EN2: rdata <= en2_reg;
          `CCU_A_PRIO2: rdata <= prio2_reg;
          `CCU_A_C1CTL: rdata <= {2'b00, ctl_reg[0]};
          `CCU_A_C1LO: rdata <= val_reg[0][7:0];
          `CCU_A_C1HI: rdata <= val_reg[0][W-1:8];
          `CCU_A_C2CTL: rdata <= {2'b00, ctl_reg[1]};
          `CCU_A_C2LO: rdata <= val_reg[1][7:0];
          `CCU_A_C2HI: rdata <= val_reg[1][W-1:8];
          `CCU_A_T1LO: rdata <= first_timer[7:0];
          `CCU_A_T1HI: rdata <= first_timer[W-1:8];
          `CCU_A_FLAGS1: rdata <= {5'h00, flag_reg[0], 2'b00};
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/ccu_monitor.sv ====
`include "ccu_consts.vh"
`default_nettype none
module ccu_monitor #(
  parameter W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [1:0] chan_pin_in,
  input wire logic [1:0] port_c_direction,
  input wire logic [1:0] port_latch,
  input wire logic [1:0] chan_pin_out,
  input wire logic [1:0] chan_pin_oe_n,
  input wire logic [W-1:0] first_timer,
  input wire logic first_timer_clear,
  input wire logic adc_start,
  input wire logic t3_overflow_irq,
  input wire logic [1:0] chan_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] m1;
  logic en_sh;
  // ----------------------------------------
  // shadows of software-written fields
  // ----------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      m1 <= 4'h0;
      en_sh <= 1'b0;
    end else if (wr) begin
      if (addr == `CCU_A_C1CTL) m1 <= wdata[3:0];
      if (addr == `CCU_A_EN2) en_sh <= wdata[1];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  AST_CTL_TOP: assert property ($past(rd) && $past(addr) == `CCU_A_C1CTL |-> rdata[7:6] == 2'b00)
    else $error("control top bits not zero");
  AST_OV_EN: assert property (t3_overflow_irq |-> en_sh || $past(en_sh))
    else $error("overflow request while disabled");
  AST_OFF_LOW: assert property (wr && addr == `CCU_A_C1CTL && wdata[3:0] == 4'h0 |-> ##2 !chan_pin_out[0])
    else $error("output not low after channel off");
  AST_PRESET: assert property (wr && addr == `CCU_A_C1CTL && wdata[3:1] == 3'b100
    |-> ##2 chan_pin_out[0] == $past(wdata[0], 2))
    else $error("compare output preset wrong");
  AST_TRIG: assert property (first_timer_clear |-> m1 == `CCU_M_TRIG || $past(m1) == `CCU_M_TRIG)
    else $error("timer clear outside trigger mode");
  AST_CAPT: assert property (m1 == `CCU_M_CAP_RISE && port_c_direction[0] && $rose(chan_pin_in[0])
    |-> ##[1:10] chan_irq[0])
    else $error("rising edge not captured");
  AST_STICKY: assert property ($fell(chan_irq[0]) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("channel flag cleared without write");
endmodule
bind ccu_top ccu_monitor #(.W(W)) u_mon (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .chan_pin_in(chan_pin_in), .port_c_direction(port_c_direction), .port_latch(port_latch),
  .chan_pin_out(chan_pin_out), .chan_pin_oe_n(chan_pin_oe_n), .first_timer(first_timer),
  .first_timer_clear(first_timer_clear), .adc_start(adc_start),
  .t3_overflow_irq(t3_overflow_irq), .chan_irq(chan_irq)
);
`default_nettype wire

// ==== tb/ccu_partner.sv ====
`default_nettype none
module ccu_partner (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic first_timer_clear,
  output logic [15:0] first_timer,
  output logic [1:0] chan_pin_in = 2'b00
);
  timeunit 1ns;
  timeprecision 1ns;
  logic run = 1'b0;
  logic ld = 1'b0;
  logic [15:0] ldv = 16'h0000;
  int clr_cnt = 0;
  // ----------------------------------------
  // time base, may also stand still
  // ----------------------------------------
  // counts on the system clock only; an async count would miss clears
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) first_timer <= 16'h0000;
    else if (ld) first_timer <= ldv;
    else if (first_timer_clear) begin
      first_timer <= 16'h0000;
      clr_cnt <= clr_cnt + 1;
    end else if (run) first_timer <= first_timer + 16'h0001;
  end
  task load(input logic [15:0] v, input logic r);
    @(negedge mclk);
    ldv = v;
    ld = 1'b1;
    run = r;
    @(negedge mclk);
    ld = 1'b0;
  endtask
  // pin moves off the clock edge, held long enough for the synchroniser
  task pin(input int ch, input logic v);
    #7 chan_pin_in[ch] = v;
    repeat (6) @(posedge mclk);
  endtask
  task pulse(input int n);
    repeat (n) begin
      pin(0, 1'b1);
      pin(0, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/test_capture_compare_unit_with_timer_reset.sv ====
`include "ccu_consts.vh"
`default_nettype none
module test_capture_compare_unit_with_timer_reset;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] dir = 2'b11;
  logic [1:0] latch = 2'b00;
  wire [7:0] rdata;
  wire [1:0] pin_in, pin_out, oe_n, irq;
  wire [15:0] ftm;
  wire ft_clr, adc, ov_irq;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int c0;
  logic [7:0] d;
  logic [15:0] v;
  logic [3:0] mq[$] = '{4'h2, 4'hA, 4'h8, 4'h9, 4'hB};
  logic ex[$] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  always #20 mclk = ~mclk;
  ccu_top #(.W(16)) dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .chan_pin_in(pin_in), .port_c_direction(dir), .port_latch(latch),
    .chan_pin_out(pin_out), .chan_pin_oe_n(oe_n), .first_timer(ftm), .first_timer_clear(ft_clr),
    .adc_start(adc), .t3_overflow_irq(ov_irq), .chan_irq(irq));
  ccu_partner p (.mclk(mclk), .rst_n(rst_n), .first_timer_clear(ft_clr), .first_timer(ftm),
    .chan_pin_in(pin_in));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task wreg(input logic [3:0] a, input logic [7:0] q);
    @(posedge mclk);
    addr <= a;
    wdata <= q;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task rchk(input string n, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
    chk(n, {8'h00, d & m}, {8'h00, e});
  endtask
  task print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'hB9F7CD7C));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rchk("prio2", `CCU_A_PRIO2, 8'hFF, `CCU_PRIO2_RST);
    rchk("t3ctl", `CCU_A_T3CTL, 8'hFF, 8'h00);
    rchk("unmapped", 4'hF, 8'hFF, 8'h00);
    repeat (4) begin
      v = 16'($urandom);
      d = 8'($urandom);
      wreg(`CCU_A_C1CTL, {d[7:4], 4'h0});
      rchk("c1ctl", `CCU_A_C1CTL, 8'hFF, {2'b00, d[5:4], 4'h0});
      wreg(`CCU_A_C1LO, v[7:0]);
      wreg(`CCU_A_C1HI, v[15:8]);
      rchk("c1lo", `CCU_A_C1LO, 8'hFF, v[7:0]);
      rchk("c1hi", `CCU_A_C1HI, 8'hFF, v[15:8]);
    end
    $display("test registers done");
    wreg(`CCU_A_C1CTL, {4'h0, `CCU_M_CAP_RISE});
    wreg(`CCU_A_FLAGS1, 8'h00);
    repeat (2) begin
      v = 16'($urandom);
      p.load(v, 1'b0);
      p.pulse(1);
    end
    rchk("capflag", `CCU_A_FLAGS1, 8'h04, 8'h04);
    rchk("caplo", `CCU_A_C1LO, 8'hFF, v[7:0]);
    rchk("caphi", `CCU_A_C1HI, 8'hFF, v[15:8]);
    wreg(`CCU_A_C1CTL, 8'h00);
    wreg(`CCU_A_C1CTL, {4'h0, `CCU_M_CAP_FALL});
    wreg(`CCU_A_FLAGS1, 8'h00);
    p.pin(0, 1'b1);
    rchk("fallrise", `CCU_A_FLAGS1, 8'h04, 8'h00);
    p.load(16'hA55A, 1'b0);
    p.pin(0, 1'b0);
    rchk("fallflag", `CCU_A_FLAGS1, 8'h04, 8'h04);
    rchk("fallhi", `CCU_A_C1HI, 8'hFF, 8'hA5);
    $display("test capture done");
    for (int k = 0; k < 2; k++) begin
      wreg(`CCU_A_C1CTL, 8'h00);
      wreg(`CCU_A_C1CTL, {4'h0, k ? `CCU_M_CAP_16 : `CCU_M_CAP_4});
      p.pulse(2);
      wreg(`CCU_A_C1CTL, 8'h00);
      wreg(`CCU_A_C1CTL, {4'h0, k ? `CCU_M_CAP_16 : `CCU_M_CAP_4});
      wreg(`CCU_A_FLAGS1, 8'h00);
      p.pulse(k ? 15 : 3);
      rchk("psearly", `CCU_A_FLAGS1, 8'h04, 8'h00);
      p.pulse(1);
      rchk("psflag", `CCU_A_FLAGS1, 8'h04, 8'h04);
    end
    $display("test prescale done");
    wreg(`CCU_A_C1CTL, 8'h00);
    wreg(`CCU_A_C1CTL, {4'h0, `CCU_M_CAP_RISE});
    dir <= 2'b10;
    wreg(`CCU_A_FLAGS1, 8'h00);
    latch <= 2'b01;
    repeat (8) @(posedge mclk);
    rchk("latchcap", `CCU_A_FLAGS1, 8'h04, 8'h04);
    chk("oe_n", {14'h0000, oe_n}, 16'h0002);
    dir <= 2'b11;
    latch <= 2'b00;
    $display("test port write done");
    wreg(`CCU_A_C1CTL, 8'h00);
    wreg(`CCU_A_C1LO, 8'h40);
    wreg(`CCU_A_C1HI, 8'h12);
    foreach (mq[i]) begin
      c0 = p.clr_cnt;
      wreg(`CCU_A_FLAGS1, 8'h00);
      wreg(`CCU_A_C1CTL, {4'h0, mq[i]});
      p.load(16'h123A, 1'b1);
      repeat (14) @(posedge mclk);
      p.load(16'h0100, 1'b0);
      rchk("cmpflag", `CCU_A_FLAGS1, 8'h04, 8'h04);
      if (mq[i] == `CCU_M_TRIG) chk("clr", {15'h0000, p.clr_cnt != c0}, 16'h0001);
      else chk("cmpout", {15'h0000, pin_out[0]}, {15'h0000, ex[i]});
    end
    wreg(`CCU_A_C1CTL, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk("offout", {15'h0000, pin_out[0]}, 16'h0000);
    $display("test compare done");
    wreg(`CCU_A_T3HI, 8'hFF);
    wreg(`CCU_A_T3LO, 8'hF0);
    wreg(`CCU_A_FLAGS2, 8'h00);
    wreg(`CCU_A_EN2, 8'h02);
    wreg(`CCU_A_T3CTL, 8'h41);
    repeat (40) @(posedge mclk);
    rchk("t3wrap", `CCU_A_FLAGS2, 8'h02, 8'h02);
    chk("ovirq", {15'h0000, ov_irq}, 16'h0001);
    wreg(`CCU_A_EN2, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk("ovmask", {15'h0000, ov_irq}, 16'h0000);
    wreg(`CCU_A_C1LO, 8'h20);
    wreg(`CCU_A_C1HI, 8'h00);
    wreg(`CCU_A_C1CTL, {4'h0, `CCU_M_TRIG});
    wreg(`CCU_A_T3HI, 8'h00);
    wreg(`CCU_A_T3LO, 8'h00);
    wreg(`CCU_A_FLAGS2, 8'h00);
    wreg(`CCU_A_FLAGS1, 8'h00);
    repeat (200) @(posedge mclk);
    rchk("trigovf", `CCU_A_FLAGS2, 8'h02, 8'h00);
    rchk("trigflag", `CCU_A_FLAGS1, 8'h04, 8'h04);
    rchk("t3lo", `CCU_A_T3LO, 8'hC0, 8'h00);
    $display("test third timer done");
    print_verdict();
  end
endmodule
`default_nettype wire
